// *** inc/channel_reclock_cfg.svh ***
// Offsets, reset values and field widths for the channel
// reclock mode control block. Definitions only; included by bare name.
`ifndef CHANNEL_RECLOCK_CFG_SVH
`define CHANNEL_RECLOCK_CFG_SVH

// ==========================================================
// Register byte offsets on the APB window.
// ==========================================================
`define OFS_MODE 8'h00
`define OFS_REPORT_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STS 8'h0c
`define OFS_IRQ_MASK 8'h10

// ==========================================================
// Field widths: one mode field and one status field per channel.
// ==========================================================
`define MODE_W 3
`define STAT_W 2

// ==========================================================
// Reset values.
// ==========================================================
`define REPORT_EN_RST 1'b1
`define IRQ_MASK_RST 1'b0
`define RDATA_RST 32'h0000_0000

`endif

// *** inc/channel_reclock_pkg.sv ***
// Types shared by the channel reclock mode control block and its decoder.
// Assumes one rate classifier per channel outside this block.
`default_nettype none

package channel_reclock_pkg;

    // Operating mode of one channel; auto_with_mute is the default.
    typedef enum logic [2:0] {
        auto_with_mute = 3'h0,
        fixed_sd_with_mute = 3'h1,
        fixed_hd_with_mute = 3'h2,
        auto_with_bypass = 3'h3,
        fixed_bypass = 3'h4
    } chan_mode_t;

    // Class of the detected input bit rate.
    typedef enum logic [2:0] {
        rate_none = 3'h0,
        rate_sd = 3'h1,
        rate_hd = 3'h2,
        rate_high = 3'h3,
        rate_low = 3'h4
    } rate_class_t;

    // Reported input state; stat_off while reporting is disabled.
    typedef enum logic [1:0] {
        stat_off = 2'h0,
        stat_present = 2'h1,
        stat_not_present = 2'h2,
        stat_not_monitored = 2'h3
    } in_stat_t;

    // Steering of the analog path of one channel.
    typedef struct packed {
        logic reclock;
        logic hd_rate;
        logic mute;
        logic bypass;
        logic sd_slew;
        in_stat_t status;
    } chan_ctrl_t;

endpackage : channel_reclock_pkg

`default_nettype wire

// *** logic/chan_mode_decode.sv ***
// Decoder from mode, detected rate and report enable to path steering.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module chan_mode_decode
(
    input wire channel_reclock_pkg::chan_mode_t mode,
    input wire channel_reclock_pkg::rate_class_t rate,
    input wire logic report_en,
    output channel_reclock_pkg::chan_ctrl_t ctrl
);
    import channel_reclock_pkg::*;

    // Status before the report gate.
    in_stat_t raw;
    // True when the rate is one the reclocker locks to.
    logic std_rate;

    // ==========================================================
    // Mode decode.
    // ==========================================================
    // One case per mode; every path sets every field.
    always_comb
    begin
        std_rate = (rate == rate_sd) || (rate == rate_hd);
        ctrl = '0;
        raw = stat_not_present;
        case (mode)
            fixed_sd_with_mute:
            begin
                // Only standard rate is forwarded.
                ctrl.reclock = (rate == rate_sd);
                ctrl.mute = (rate != rate_sd);
                raw = (rate == rate_sd) ? stat_present : stat_not_present;
            end
            fixed_hd_with_mute:
            begin
                // Only high rate is forwarded.
                ctrl.reclock = (rate == rate_hd);
                ctrl.hd_rate = (rate == rate_hd);
                ctrl.mute = (rate != rate_hd);
                raw = (rate == rate_hd) ? stat_present : stat_not_present;
            end
            auto_with_bypass:
            begin
                // Locked rates reclock; anything else passes straight through.
                ctrl.reclock = std_rate;
                ctrl.hd_rate = (rate == rate_hd);
                ctrl.bypass = !std_rate;
                raw = std_rate ? stat_present : stat_not_monitored;
            end
            fixed_bypass:
            begin
                // Bypass whatever arrives, with the slow edge on the coax drivers.
                ctrl.bypass = 1'b1;
                ctrl.sd_slew = 1'b1;
                // Anything above the carrier floor counts as present.
                if (std_rate || rate == rate_high)
                begin
                    raw = stat_present;
                end
                else
                begin
                    raw = stat_not_monitored;
                end
            end
            default:
            begin
                // Auto with mute, also the fallback for any stray code.
                ctrl.reclock = std_rate;
                ctrl.hd_rate = (rate == rate_hd);
                ctrl.mute = !std_rate;
                raw = std_rate ? stat_present : stat_not_present;
            end
        endcase
        // Status is only published while reporting is on.
        ctrl.status = report_en ? raw : stat_off;
    end

endmodule : chan_mode_decode

`default_nettype wire

// *** logic/channel_reclock_mode_control.sv ***
// Per-channel mode control for a four-channel reclocking converter.
// Assumes APB from the frame controller, switch codes synchronous to
// pclk, and one rate class per channel from the rate detectors.
//
// Notes on behaviour
// - Four channels, each holding one of five modes.
// - Auto mute: locked rate reclocks, reports present.
// - Auto mute: other or none mutes, not present.
// - Fixed SD: only standard rate passes, else mute.
// - Fixed HD: only high rate passes, else mute.
// - Auto bypass: locked rates reclock, report present.
// - Auto bypass: others bypassed, reported not monitored.
// - Fixed bypass: reclocker always bypassed to outputs.
// - SD slew on coax drivers only in fixed bypass.
// - Fixed bypass: above floor present, else not monitored.
// - Status is published only while reporting enabled.
// - Mode follows switches or remote, whichever last.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "channel_reclock_cfg.svh"

module channel_reclock_mode_control
#(
    parameter int NUM_CH = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire channel_reclock_pkg::chan_mode_t [NUM_CH-1:0] sw_mode,
    input wire channel_reclock_pkg::rate_class_t [NUM_CH-1:0] rate,
    output channel_reclock_pkg::chan_ctrl_t [NUM_CH-1:0] chan_ctrl,
    output logic irq
);
    import channel_reclock_pkg::*;

    // ==========================================================
    // Elaboration check.
    // ==========================================================
    // The mode register packs three bits per channel into one word.
    if (NUM_CH < 1 || NUM_CH > 8)
    begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 8");
    end

    // ==========================================================
    // State.
    // ==========================================================
    // All flip-flops of the block, registered as one word.
    typedef struct packed {
        chan_mode_t [NUM_CH-1:0] mode;
        chan_mode_t [NUM_CH-1:0] sw_prev;
        logic [NUM_CH-1:0] rep_en;
        logic [NUM_CH-1:0] sts;
        logic [NUM_CH-1:0] mask;
        chan_ctrl_t [NUM_CH-1:0] ctrl;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    // Current and next state.
    state_t st_q;
    state_t st_d;
    // Decoded steering for each channel, from current mode and rate.
    chan_ctrl_t [NUM_CH-1:0] dec;

    // ==========================================================
    // Per-channel decoders.
    // ==========================================================
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_dec
        chan_mode_decode u_dec
        (
            .mode(st_q.mode[g]),
            .rate(rate[g]),
            .report_en(st_q.rep_en[g]),
            .ctrl(dec[g])
        );
    end

    // Access phase in its first cycle: the answer is prepared now.
    logic acc_first;
    // Access phase completing at this edge.
    logic acc_done;
    // Address hits, one per register.
    logic hit_mode;
    logic hit_rep;
    logic hit_stat;
    logic hit_ists;
    logic hit_imask;

    // ==========================================================
    // Address decode.
    // ==========================================================
    // Plain chain over the held address.
    always_comb
    begin
        hit_mode = 1'b0;
        hit_rep = 1'b0;
        hit_stat = 1'b0;
        hit_ists = 1'b0;
        hit_imask = 1'b0;
        if (paddr == `OFS_MODE)
        begin
            hit_mode = 1'b1;
        end
        else if (paddr == `OFS_REPORT_EN)
        begin
            hit_rep = 1'b1;
        end
        else if (paddr == `OFS_STATUS)
        begin
            hit_stat = 1'b1;
        end
        else if (paddr == `OFS_IRQ_STS)
        begin
            hit_ists = 1'b1;
        end
        else if (paddr == `OFS_IRQ_MASK)
        begin
            hit_imask = 1'b1;
        end
    end

    // ==========================================================
    // Next state.
    // ==========================================================
    // Every access waits exactly one cycle: pready rises in the second
    // access cycle, so the read word always comes from a flip-flop.
    always_comb
    begin
        logic [31:0] rd;
        logic [NUM_CH-1:0] clr;
        logic [NUM_CH-1:0] ev;
        rd = 32'h0000_0000;
        clr = '0;
        ev = '0;
        st_d = st_q;
        acc_first = psel && penable && !st_q.pready;
        acc_done = psel && penable && st_q.pready;
        st_d.pready = acc_first;
        st_d.pslverr = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Path and status follow rate and mode every cycle.
            st_d.ctrl[i] = dec[i];
            ev[i] = (dec[i].status != st_q.ctrl[i].status);
            // A moved switch is a fresh local selection.
            if (sw_mode[i] != st_q.sw_prev[i] && sw_mode[i] <= fixed_bypass)
            begin
                st_d.mode[i] = sw_mode[i];
            end
            // Read word assembly.
            if (hit_mode)
            begin
                rd[`MODE_W*i +: `MODE_W] = st_q.mode[i];
            end
            else if (hit_stat)
            begin
                rd[`STAT_W*i +: `STAT_W] = st_q.ctrl[i].status;
            end
        end
        st_d.sw_prev = sw_mode;
        if (hit_rep)
        begin
            rd[NUM_CH-1:0] = st_q.rep_en;
        end
        else if (hit_ists)
        begin
            rd[NUM_CH-1:0] = st_q.sts;
        end
        else if (hit_imask)
        begin
            rd[NUM_CH-1:0] = st_q.mask;
        end
        // Answer is latched in the first access cycle.
        if (acc_first)
        begin
            st_d.prdata = pwrite ? `RDATA_RST : rd;
            st_d.pslverr = !(hit_mode || hit_rep || hit_stat || hit_ists || hit_imask);
        end
        // Writes take effect at the completing edge only.
        if (acc_done && pwrite)
        begin
            if (hit_mode)
            begin
                for (int i = 0; i < NUM_CH; i++)
                begin
                    // Stray codes leave that channel unchanged.
                    if (pwdata[`MODE_W*i +: `MODE_W] <= fixed_bypass)
                    begin
                        st_d.mode[i] = chan_mode_t'(pwdata[`MODE_W*i +: `MODE_W]);
                    end
                end
            end
            else if (hit_rep)
            begin
                st_d.rep_en = pwdata[NUM_CH-1:0];
            end
            else if (hit_ists)
            begin
                clr = pwdata[NUM_CH-1:0];
            end
            else if (hit_imask)
            begin
                st_d.mask = pwdata[NUM_CH-1:0];
            end
        end
        // A status change in the clearing cycle is kept: set wins.
        st_d.sts = (st_q.sts & ~clr) | ev;
        st_d.irq = |(st_d.sts & st_d.mask);
    end

    // ==========================================================
    // State register.
    // ==========================================================
    // Reset: every channel in auto with mute, reporting on, no events.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
            st_q.rep_en <= {NUM_CH{`REPORT_EN_RST}};
            st_q.mask <= {NUM_CH{`IRQ_MASK_RST}};
            st_q.prdata <= `RDATA_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state word.
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign chan_ctrl = st_q.ctrl;
    assign irq = st_q.irq;

    // ==========================================================
    // Assertions.
    // ==========================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chk
        a_auto_reclock: assert property (
            st_q.mode[g] == auto_with_mute && rate[g] inside {rate_sd, rate_hd}
            |=> chan_ctrl[g].reclock && !chan_ctrl[g].mute
                && chan_ctrl[g].hd_rate == ($past(rate[g]) == rate_hd))
        else $error("auto mode did not reclock a locked rate");
        a_auto_mute: assert property (
            st_q.mode[g] == auto_with_mute && !(rate[g] inside {rate_sd, rate_hd})
            |=> chan_ctrl[g].mute && !chan_ctrl[g].reclock && !chan_ctrl[g].bypass)
        else $error("auto mode did not mute an unlocked input");
        a_sd_only: assert property (
            st_q.mode[g] == fixed_sd_with_mute
            |=> chan_ctrl[g].mute == ($past(rate[g]) != rate_sd))
        else $error("fixed standard mode passed a wrong rate");
        a_hd_only: assert property (
            st_q.mode[g] == fixed_hd_with_mute
            |=> chan_ctrl[g].reclock == ($past(rate[g]) == rate_hd))
        else $error("fixed high mode reclocked a wrong rate");
        a_byp_other: assert property (
            st_q.mode[g] == auto_with_bypass && st_q.rep_en[g]
            && !(rate[g] inside {rate_sd, rate_hd})
            |=> chan_ctrl[g].bypass && chan_ctrl[g].status == stat_not_monitored)
        else $error("auto bypass did not bypass an unlocked input");
        a_fixed_byp: assert property (
            st_q.mode[g] == fixed_bypass
            |=> chan_ctrl[g].bypass && !chan_ctrl[g].mute && !chan_ctrl[g].reclock)
        else $error("fixed bypass did not bypass");
        a_slew_only: assert property (
            chan_ctrl[g].sd_slew |-> $past(st_q.mode[g]) == fixed_bypass)
        else $error("slow slew outside fixed bypass");
        a_report_off: assert property (
            !st_q.rep_en[g] |=> chan_ctrl[g].status == stat_off)
        else $error("status published while reporting is off");
        a_switch_take: assert property (
            sw_mode[g] != st_q.sw_prev[g] && sw_mode[g] <= fixed_bypass
            && !(acc_done && pwrite && hit_mode)
            |=> st_q.mode[g] == $past(sw_mode[g]))
        else $error("switch selection not applied");
        a_sticky_set: assert property (
            chan_ctrl[g].status != $past(chan_ctrl[g].status) |-> st_q.sts[g])
        else $error("status change lost its event bit");
    end

    a_irq_level: assert property (
        irq == |(st_q.sts & st_q.mask))
    else $error("interrupt level disagrees with status and mask");

endmodule : channel_reclock_mode_control

`default_nettype wire

// *** verification/channel_reclock_mode_control_test.sv ***
// Self-checking bench for the channel mode control block, driven over APB.
// Assumes the far-side model supplies rate classes and switch codes.
`timescale 1ns/10ps
`default_nettype none
`include "channel_reclock_cfg.svh"

module channel_reclock_mode_control_test;
    import channel_reclock_pkg::*;

    localparam int NUM_CH = 4;

    logic pclk; // Bus clock, 8 ns period.
    logic presetn; // Active-low reset.
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq;
    rate_class_t [NUM_CH-1:0] rate_req, rate; // Requested and delivered rates.
    chan_mode_t [NUM_CH-1:0] sw_req, sw_mode; // Requested and delivered switches.
    chan_ctrl_t [NUM_CH-1:0] chan_ctrl; // Steering seen at the outputs.
    chan_mode_t em [NUM_CH]; // Mode each channel should hold.
    logic [3:0] ren; // Report enables the bench expects.
    int mismatches, checks;

    // ==========================================================
    // Instances
    // ==========================================================
    channel_reclock_mode_control #(.NUM_CH(NUM_CH)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw_mode(sw_mode),
        .rate(rate), .chan_ctrl(chan_ctrl), .irq(irq));
    video_source_model #(.NUM_CH(NUM_CH)) src (.pclk(pclk), .presetn(presetn),
        .rate_req(rate_req), .sw_req(sw_req), .rate(rate), .sw_mode(sw_mode));

    // Free-running clock.
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    // Expected steering, worked out independently of the design's decoder.
    function automatic chan_ctrl_t exp_ctrl(chan_mode_t m, rate_class_t r, logic en);
        chan_ctrl_t e;
        logic ok;
        e = '0;
        if (m == fixed_bypass)
        begin
            e.bypass = 1'b1;
            e.sd_slew = 1'b1;
            e.status = (r inside {rate_sd, rate_hd, rate_high}) ? stat_present : stat_not_monitored;
        end
        else
        begin
            ok = (m == fixed_sd_with_mute) ? (r == rate_sd) :
                 (m == fixed_hd_with_mute) ? (r == rate_hd) : (r inside {rate_sd, rate_hd});
            e.reclock = ok;
            e.hd_rate = ok && (r == rate_hd);
            e.mute = !ok && (m != auto_with_bypass);
            e.bypass = !ok && (m == auto_with_bypass);
            e.status = ok ? stat_present :
                       (m == auto_with_bypass) ? stat_not_monitored : stat_not_present;
        end
        if (!en)
            e.status = stat_off;
        return e;
    endfunction : exp_ctrl

    // One comparison; a mismatch is reported at once.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_er);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk("write error", 32'(exp_er), 32'(er));
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                       input logic exp_er);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(nm, exp, rd);
        chk("read error", 32'(exp_er), 32'(er));
    endtask : rdc

    // Lets rate and mode settle, then checks every channel and the status word.
    task automatic chk_all();
        chan_ctrl_t e;
        logic [31:0] sw;
        repeat (4) @(posedge pclk);
        #1;
        sw = 32'h0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            e = exp_ctrl(em[c], rate_req[c], ren[c]);
            chk("chan_ctrl", 32'(e), 32'(chan_ctrl[c]));
            sw[2*c +: 2] = e.status;
        end
        rdc("status", `OFS_STATUS, sw, 1'b0);
    endtask : chk_all

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // A hang counts as a mismatch and ends the run in the usual place.
    initial
    begin
        #(8 * 20000);
        $display("MISMATCH watchdog expected done seen hang");
        mismatches++;
        summarize();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        logic [31:0] w;
        mismatches = 0;
        checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rate_req = {NUM_CH{rate_none}};
        sw_req = {NUM_CH{auto_with_mute}};
        ren = 4'hf;
        foreach (em[c]) em[c] = auto_with_mute;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("mode reset", `OFS_MODE, 32'h0, 1'b0);
        rdc("report reset", `OFS_REPORT_EN, 32'hf, 1'b0);
        rdc("mask reset", `OFS_IRQ_MASK, 32'h0, 1'b0);
        rdc("sts after reset", `OFS_IRQ_STS, 32'hf, 1'b0);
        chk_all();
        $display("test reset done");
        // A switch change is adopted for its own channel only.
        @(posedge pclk);
        sw_req[2] <= fixed_bypass;
        em[2] = fixed_bypass;
        chk_all();
        rdc("mode by switch", `OFS_MODE, 32'h100, 1'b0);
        $display("test switch done");
        // Every mode meets every rate class, one class per channel at a time.
        for (int mi = 0; mi < 5; mi++)
        begin
            w = 32'h0;
            for (int c = 0; c < NUM_CH; c++)
            begin
                w |= 32'(mi) << (3 * c);
                em[c] = chan_mode_t'(3'(mi));
            end
            wr(`OFS_MODE, w, 1'b0);
            for (int r = 0; r < 5; r++)
            begin
                @(posedge pclk);
                for (int c = 0; c < NUM_CH; c++)
                    rate_req[c] <= rate_class_t'(3'((r + c) % 5));
                chk_all();
            end
        end
        $display("test sweep done");
        // Static switches do not take back a remote write; stray codes are ignored.
        wr(`OFS_MODE, 32'h0, 1'b0);
        rdc("mode remote", `OFS_MODE, 32'h0, 1'b0);
        wr(`OFS_MODE, 32'h24d, 1'b0);
        foreach (em[c]) em[c] = (c == 0) ? auto_with_mute : fixed_sd_with_mute;
        rdc("mode stray", `OFS_MODE, 32'h248, 1'b0);
        // A switch moved after a remote write wins, and so does moving it back.
        @(posedge pclk);
        sw_req[0] <= fixed_hd_with_mute;
        em[0] = fixed_hd_with_mute;
        chk_all();
        rdc("mode switch after write", `OFS_MODE, 32'h24a, 1'b0);
        @(posedge pclk);
        sw_req[0] <= auto_with_mute;
        em[0] = auto_with_mute;
        chk_all();
        $display("test mode write done");
        wr(`OFS_REPORT_EN, 32'h5, 1'b0);
        ren = 4'h5;
        chk_all();
        wr(`OFS_REPORT_EN, 32'hf, 1'b0);
        ren = 4'hf;
        wr(`OFS_STATUS, 32'h0, 1'b0);
        chk_all();
        wr(8'h20, 32'hffff_ffff, 1'b1);
        rdc("unmapped", 8'h20, 32'h0, 1'b1);
        $display("test report and map done");
        // Interrupt: raise, mask, unmask, clear.
        @(posedge pclk);
        rate_req <= {NUM_CH{rate_none}};
        chk_all();
        wr(`OFS_IRQ_STS, 32'hf, 1'b0);
        rdc("sts cleared", `OFS_IRQ_STS, 32'h0, 1'b0);
        wr(`OFS_IRQ_MASK, 32'h1, 1'b0);
        @(posedge pclk);
        rate_req[0] <= rate_sd;
        chk_all();
        rdc("sts raised", `OFS_IRQ_STS, 32'h1, 1'b0);
        chk("irq raised", 32'h1, 32'(irq));
        wr(`OFS_IRQ_MASK, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq masked", 32'h0, 32'(irq));
        wr(`OFS_IRQ_MASK, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq unmasked", 32'h1, 32'(irq));
        wr(`OFS_IRQ_STS, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq cleared", 32'h0, 32'(irq));
        rdc("sts after clear", `OFS_IRQ_STS, 32'h0, 1'b0);
        $display("test interrupt done");
        summarize();
    end
endmodule : channel_reclock_mode_control_test

`default_nettype wire

// *** verification/video_source_model.sv ***
// Far-side model: the rate detector of each channel and the local mode switches.
// Assumes the bench sets the requested values; they reach the block only at pclk edges.
`timescale 1ns/10ps
`default_nettype none

module video_source_model
#(
    parameter int NUM_CH = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire channel_reclock_pkg::rate_class_t [NUM_CH-1:0] rate_req,
    input wire channel_reclock_pkg::chan_mode_t [NUM_CH-1:0] sw_req,
    output var channel_reclock_pkg::rate_class_t [NUM_CH-1:0] rate,
    output var channel_reclock_pkg::chan_mode_t [NUM_CH-1:0] sw_mode
);
    import channel_reclock_pkg::*;

    // ==========================================================
    // Registered outputs
    // ==========================================================
    // Both outputs change only just after a rising edge, so the block never sees a
    // code that flips in the middle of a cycle, as a real synchronised switch would not.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate <= {NUM_CH{rate_none}};
            sw_mode <= {NUM_CH{auto_with_mute}};
        end
        else
        begin
            rate <= rate_req;
            sw_mode <= sw_req;
        end
    end
endmodule : video_source_model

`default_nettype wire
